// ---- fpd_chk.sv ----
// ports checker for the pulse divider
`timescale 1ns/10ps
module fpd_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic feedback_phase_first_out,
	input wire logic feedback_phase_first_out_n,
	input wire logic feedback_phase_second_out,
	input wire logic feedback_phase_second_out_n,
	input wire logic feedback_index_out,
	input wire logic feedback_index_out_n,
	input wire logic setting_alarm,
	input wire logic overspeed_alarm,
	input wire fpd_pkg::fpd_dir_type move_dir
);
	import fpd_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire pa = feedback_phase_first_out;
	wire pb = feedback_phase_second_out;
	wire px = feedback_index_out;
	wire rs_wr = psel && penable && pwrite && paddr == 12'h000 && pwdata[3];
	sequence a_rise; $rose(pa); endsequence
	sequence a_fall; $fell(pa); endsequence
	chk_pair_levels: assert property (pa != feedback_phase_first_out_n && pb != feedback_phase_second_out_n)
		else $error("phase pair not complementary");
	chk_index_levels: assert property (px != feedback_index_out_n)
		else $error("index pair not complementary");
	chk_one_phase: assert property (!($changed(pa) && $changed(pb)))
		else $error("both phases moved at once");
	chk_index_start: assert property ($rose(px) |-> a_rise)
		else $error("index rose off first phase edge");
	chk_index_end: assert property ($fell(px) |-> a_fall)
		else $error("index fell off first phase edge");
	chk_alarm_halt: assert property (setting_alarm && $past(setting_alarm) |-> $stable(pa) && $stable(pb))
		else $error("output moved under setting alarm");
	chk_step_dir: assert property ($changed(pa) || $changed(pb) |-> move_dir != FPD_DIR_NONE)
		else $error("output step with no direction");
	chk_ovs_hold: assert property ($fell(overspeed_alarm) |-> $past(rs_wr) || $past(rs_wr, 2) || $past(rs_wr, 3))
		else $error("overspeed cleared without restart");
	chk_apb_err: assert property (psel && penable && paddr >= 12'h020 |-> pslverr)
		else $error("unmapped access not refused");
endmodule : fpd_chk
bind fpd_top fpd_chk u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .feedback_phase_first_out,
	.feedback_phase_first_out_n, .feedback_phase_second_out, .feedback_phase_second_out_n, .feedback_index_out,
	.feedback_index_out_n, .setting_alarm, .overspeed_alarm, .move_dir);

// ---- fpd_consts.svh ----
// register offsets, field positions, reset values and fixed factors of the pulse divider
`ifndef FPD_CONSTS_SVH
`define FPD_CONSTS_SVH

// ***************************************
// register byte offsets
// ***************************************
`define FPD_OFF_CTRL 12'h000
`define FPD_OFF_RES 12'h004
`define FPD_OFF_PITCH 12'h008
`define FPD_OFF_MAXSPD 12'h00c
`define FPD_OFF_EDGES 12'h010
`define FPD_OFF_STATUS 12'h014
`define FPD_OFF_MON_LO 12'h018
`define FPD_OFF_MON_HI 12'h01c

// ***************************************
// control and status fields
// ***************************************
`define FPD_CTRL_IDX_DIR 0
`define FPD_CTRL_SERIAL 1
`define FPD_CTRL_REV_SEL 2
`define FPD_CTRL_RESTART 3
`define FPD_ST_SET_ERR 0
`define FPD_ST_OVERSPD 1
`define FPD_ST_PHASE_A 2
`define FPD_ST_PHASE_B 3
`define FPD_ST_INDEX 4
`define FPD_ST_DIR_LO 5
`define FPD_ST_RES_LO 8

// ***************************************
// reset values and limits
// ***************************************
`define FPD_CTRL_DEF 3'h0
`define FPD_RES_MIN 13'h0001
`define FPD_RES_MAX 13'h1000
`define FPD_RES_DEF 13'h0014
`define FPD_PITCH_DEF 32'h000007d0
`define FPD_MAXSPD_DEF 16'h0032
`define FPD_EDGES_DEF 16'h1000

// ***************************************
// limit formula factors
// ***************************************
`define FPD_PITCH_DIV 48'h0000_0000_0064
`define FPD_LIMIT_MUL 48'h0000_0000_0048
`define FPD_PITCH_4UM 32'h00000190
`define FPD_SPD_CAP_4UM 16'h000a

`endif

// ---- fpd_host.sv ----
// host side quadrature reader model
`timescale 1ns/10ps
module fpd_host (
	input wire logic clk,
	input wire logic rst,
	input wire logic ph_a,
	input wire logic ph_b,
	input wire logic idx,
	output int pos,
	output int idx_cnt
);
	logic pa_r, pb_r, px_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			pos <= 0;
		end else if ({ph_a, ph_b} != {pa_r, pb_r}) begin
			pos <= (pa_r ^ ph_b) ? pos + 1 : pos - 1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			idx_cnt <= 0;
		end else if (idx && !px_r) begin
			idx_cnt <= idx_cnt + 1;
		end
	end
	always_ff @(posedge clk) begin
		pa_r <= ph_a;
		pb_r <= ph_b;
		px_r <= idx;
	end
endmodule : fpd_host

// ---- fpd_pkg.sv ----
// shared types of the scale feedback pulse divider
package fpd_pkg;

	typedef enum logic [1:0] {
		FPD_DIR_NONE,
		FPD_DIR_FWD,
		FPD_DIR_REV
	} fpd_dir_type;

endpackage : fpd_pkg

// ---- fpd_sync2.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module fpd_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			dout <= '0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end

endmodule : fpd_sync2

// ---- fpd_top.sv ----
// scale feedback pulse divider: quadrature division, index gating, limit alarms, apb registers
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "fpd_consts.svh"
module fpd_top #(
	parameter int ZW = 2,
	parameter int NZ = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scale_a_pin,
	input wire logic scale_b_pin,
	input wire logic scale_ref_pin,
	input wire logic [ZW-1:0] scale_zero_id_pin,
	input wire logic [31:0] detected_pitch,
	input wire logic [15:0] motor_speed,
	output logic feedback_phase_first_out,
	output logic feedback_phase_first_out_n,
	output logic feedback_phase_second_out,
	output logic feedback_phase_second_out_n,
	output logic feedback_index_out,
	output logic feedback_index_out_n,
	output logic setting_alarm,
	output logic overspeed_alarm,
	output fpd_pkg::fpd_dir_type move_dir
);
	import fpd_pkg::*;

	// ***************************************
	// apb register file
	// ***************************************
	logic [2:0] ctrl_r;
	logic restart_r;
	logic [12:0] res_r;
	logic [31:0] pitch_r;
	logic [15:0] maxspd_r;
	logic [15:0] edges_r;
	logic [31:0] prdata_r;
	logic access;
	logic setup;
	logic mapped;
	logic [31:0] rd_mux;

	logic [2:0] ctrl_act_r;
	logic [12:0] res_act_r;
	logic [31:0] pitch_act_r;
	logic [15:0] maxspd_act_r;
	logic [15:0] edges_act_r;
	logic set_err_r;
	logic overspd_r;
	logic [31:0] pitch_sel;

	assign access = psel & penable;
	assign setup = psel & ~penable;
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = prdata_r;

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			`FPD_OFF_CTRL: rd_mux = {29'h0000_0000, ctrl_r};
			`FPD_OFF_RES: rd_mux = {19'h0_0000, res_r};
			`FPD_OFF_PITCH: rd_mux = pitch_r;
			`FPD_OFF_MAXSPD: rd_mux = {16'h0000, maxspd_r};
			`FPD_OFF_EDGES: rd_mux = {16'h0000, edges_r};
			`FPD_OFF_STATUS: begin
				rd_mux[`FPD_ST_SET_ERR] = set_err_r;
				rd_mux[`FPD_ST_OVERSPD] = overspd_r;
				rd_mux[`FPD_ST_PHASE_A] = feedback_phase_first_out;
				rd_mux[`FPD_ST_PHASE_B] = feedback_phase_second_out;
				rd_mux[`FPD_ST_INDEX] = feedback_index_out;
				rd_mux[`FPD_ST_DIR_LO +: 2] = move_dir;
				rd_mux[`FPD_ST_RES_LO +: 13] = res_act_r;
			end
			`FPD_OFF_MON_LO: rd_mux = {16'h0000, detected_pitch[15:0]};
			`FPD_OFF_MON_HI: rd_mux = {16'h0000, detected_pitch[31:16]};
			default: mapped = 1'b0;
		endcase
	end

	// read data captured in setup phase, valid during access
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata_r <= rd_mux;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= `FPD_CTRL_DEF;
			res_r <= `FPD_RES_DEF;
			pitch_r <= `FPD_PITCH_DEF;
			maxspd_r <= `FPD_MAXSPD_DEF;
			edges_r <= `FPD_EDGES_DEF;
			restart_r <= 1'b0;
		end else begin
			restart_r <= 1'b0;
			if (access && pwrite) begin
				case (paddr)
					`FPD_OFF_CTRL: begin
						ctrl_r <= pwdata[2:0];
						restart_r <= pwdata[`FPD_CTRL_RESTART];
					end
					`FPD_OFF_RES: res_r <= pwdata[12:0];
					`FPD_OFF_PITCH: pitch_r <= pwdata;
					`FPD_OFF_MAXSPD: maxspd_r <= pwdata[15:0];
					`FPD_OFF_EDGES: edges_r <= pwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// ***************************************
	// settings applied at restart
	// ***************************************
	// copies taken only at restart
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_act_r <= `FPD_CTRL_DEF;
			res_act_r <= `FPD_RES_DEF;
			pitch_act_r <= `FPD_PITCH_DEF;
			maxspd_act_r <= `FPD_MAXSPD_DEF;
			edges_act_r <= `FPD_EDGES_DEF;
		end else if (restart_r) begin
			ctrl_act_r <= ctrl_r;
			res_act_r <= res_r;
			pitch_act_r <= pitch_r;
			maxspd_act_r <= maxspd_r;
			edges_act_r <= edges_r;
		end
	end

	logic idx_both;
	logic serial_act;
	logic rev_sel;
	assign idx_both = ctrl_act_r[`FPD_CTRL_IDX_DIR];
	assign serial_act = ctrl_act_r[`FPD_CTRL_SERIAL];
	// stored only; phase form does not depend on it
	assign rev_sel = ctrl_act_r[`FPD_CTRL_REV_SEL];

	// ***************************************
	// limit checks and alarms
	// ***************************************
	logic [15:0] eff_spd;
	logic [47:0] res_side;
	logic [47:0] pitch_side;
	logic [47:0] spd_side;
	logic set_err_nxt;
	logic overspd_hit;

	always_comb begin
		pitch_sel = serial_act ? pitch_act_r : detected_pitch;
		eff_spd = maxspd_act_r;
		// speed cap for fine pitch on converter
		if (serial_act && pitch_sel == `FPD_PITCH_4UM && maxspd_act_r > `FPD_SPD_CAP_4UM) begin
			eff_spd = `FPD_SPD_CAP_4UM;
		end
	end

	// res * 100 * speed <= pitch * 72
	assign res_side = 48'(res_act_r) * `FPD_PITCH_DIV * 48'(eff_spd);
	assign pitch_side = pitch_sel * `FPD_LIMIT_MUL;
	assign spd_side = 48'(res_act_r) * `FPD_PITCH_DIV * 48'(motor_speed);

	assign set_err_nxt = (res_act_r < `FPD_RES_MIN) || (res_act_r > `FPD_RES_MAX) ||
		(16'(res_act_r) > edges_act_r) || (eff_spd == 16'h0000) || (res_side > pitch_side);

	assign overspd_hit = (spd_side > pitch_side) ||
		(serial_act && pitch_sel == `FPD_PITCH_4UM && motor_speed > `FPD_SPD_CAP_4UM);

	always_ff @(posedge clk) begin
		if (rst) begin
			set_err_r <= 1'b0;
		end else begin
			set_err_r <= set_err_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			overspd_r <= 1'b0;
		end else if (overspd_hit) begin
			overspd_r <= 1'b1;
		end else if (restart_r) begin
			overspd_r <= 1'b0;
		end
	end

	assign setting_alarm = set_err_r;
	assign overspeed_alarm = overspd_r;

	// ***************************************
	// scale input decode
	// ***************************************
	logic a_s;
	logic b_s;
	logic ref_s;
	logic [ZW-1:0] zid_s;
	logic [1:0] gray_now;
	logic [1:0] gray_prev_r;
	logic [1:0] step;
	logic fwd_step;
	logic rev_step;
	logic ref_prev_r;
	fpd_dir_type dir_r;

	fpd_sync2 #(.W(3 + ZW)) u_sync (
		.clk(clk),
		.rst(rst),
		.din({scale_a_pin, scale_b_pin, scale_ref_pin, scale_zero_id_pin}),
		.dout({a_s, b_s, ref_s, zid_s})
	);

	assign gray_now = {a_s, a_s ^ b_s};
	assign step = gray_now - gray_prev_r;
	assign fwd_step = step == 2'h1;
	assign rev_step = step == 2'h3;

	always_ff @(posedge clk) begin
		if (rst) begin
			gray_prev_r <= 2'h0;
			ref_prev_r <= 1'b0;
			dir_r <= FPD_DIR_NONE;
		end else begin
			gray_prev_r <= gray_now;
			ref_prev_r <= ref_s;
			if (fwd_step) begin
				dir_r <= FPD_DIR_FWD;
			end else if (rev_step) begin
				dir_r <= FPD_DIR_REV;
			end
		end
	end
	assign move_dir = dir_r;

	// ***************************************
	// edge divider and quadrature output
	// ***************************************
	logic [16:0] acc_r;
	logic [16:0] acc_sum;
	logic [1:0] q_r;
	logic [1:0] q_nxt;
	logic out_on;
	logic a_nxt;

	assign out_on = ~set_err_r;
	assign acc_sum = acc_r + 17'(res_act_r);

	// fractional division: res output edges per edges input steps
	always_ff @(posedge clk) begin
		if (rst || restart_r) begin
			acc_r <= 17'h0_0000;
		end else if (out_on && fwd_step) begin
			acc_r <= (acc_sum >= 17'(edges_act_r)) ? acc_sum - 17'(edges_act_r) : acc_sum;
		end else if (out_on && rev_step) begin
			acc_r <= (acc_r < 17'(res_act_r)) ? acc_r + 17'(edges_act_r) - 17'(res_act_r) :
				acc_r - 17'(res_act_r);
		end
	end

	always_comb begin
		q_nxt = q_r;
		if (out_on && fwd_step && acc_sum >= 17'(edges_act_r)) begin
			q_nxt = q_r + 2'h1;
		end else if (out_on && rev_step && acc_r < 17'(res_act_r)) begin
			q_nxt = q_r - 2'h1;
		end
	end
	assign a_nxt = q_nxt[1];

	always_ff @(posedge clk) begin
		if (rst) begin
			q_r <= 2'h0;
			feedback_phase_first_out <= 1'b0;
			feedback_phase_first_out_n <= 1'b1;
			feedback_phase_second_out <= 1'b0;
			feedback_phase_second_out_n <= 1'b1;
		end else begin
			q_r <= q_nxt;
			feedback_phase_first_out <= q_nxt[1];
			feedback_phase_first_out_n <= ~q_nxt[1];
			feedback_phase_second_out <= q_nxt[1] ^ q_nxt[0];
			feedback_phase_second_out_n <= ~(q_nxt[1] ^ q_nxt[0]);
		end
	end

	// ***************************************
	// zero point gating and index pulse
	// ***************************************
	logic zero_cross;
	logic cross_fwd;
	logic emit;
	logic [NZ-1:0] seen;
	logic [NZ-1:0] seen_set;
	logic idx_pend_r;

	assign zero_cross = ref_s & ~ref_prev_r & (dir_r != FPD_DIR_NONE);
	assign cross_fwd = dir_r == FPD_DIR_FWD;

	assign emit = zero_cross & out_on &
		(serial_act | cross_fwd | (idx_both & seen[zid_s]));

	// one remembered flag per zero point
	genvar gi;
	generate
		for (gi = 0; gi < NZ; gi++) begin : g_zero
			assign seen_set[gi] = zero_cross & cross_fwd & out_on & (zid_s == ZW'(gi));
			fpd_zero_flag u_flag (
				.clk(clk),
				.rst(rst),
				.clear(restart_r),
				.set(seen_set[gi]),
				.seen(seen[gi])
			);
		end
	endgenerate

	// index aligned to one first-phase high pulse
	// restart drops a pending pulse unless the first phase rises in that cycle, a running one keeps its full width
	always_ff @(posedge clk) begin
		if (rst) begin
			idx_pend_r <= 1'b0;
			feedback_index_out <= 1'b0;
			feedback_index_out_n <= 1'b1;
		end else begin
			if (restart_r) begin
				idx_pend_r <= 1'b0;
			end else if (emit) begin
				idx_pend_r <= 1'b1;
			end else if (idx_pend_r && a_nxt && !feedback_phase_first_out) begin
				idx_pend_r <= 1'b0;
			end
			if (idx_pend_r && a_nxt && !feedback_phase_first_out) begin
				feedback_index_out <= 1'b1;
				feedback_index_out_n <= 1'b0;
			end else if (!a_nxt) begin
				feedback_index_out <= 1'b0;
				feedback_index_out_n <= 1'b1;
			end
		end
	end

endmodule : fpd_top

// ---- fpd_zero_flag.sv ----
// remembers whether one zero point has been crossed forward since restart
`timescale 1ns/10ps
module fpd_zero_flag (
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic set,
	output logic seen
);

	always_ff @(posedge clk) begin
		if (rst) begin
			seen <= 1'b0;
		end else if (set) begin
			seen <= 1'b1;
		end else if (clear) begin
			seen <= 1'b0;
		end
	end

endmodule : fpd_zero_flag

// ---- scale_feedback_pulse_divider_test.sv ----
// bench: apb tasks, scale stimulus, index and alarm tests
`timescale 1ns/10ps
module scale_feedback_pulse_divider_test;
	import fpd_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, sa = 1'h0, sb = 1'h0, sr = 1'h0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q, dp = 32'h7d0;
	logic [15:0] spd = 16'h0;
	logic [1:0] zid = 2'h0, ph = 2'h0;
	logic pready, pslverr, fa, fan, fb, fbn, fx, fxn, sal, oal;
	fpd_dir_type dir;
	int pos, icnt, p0, cyc = 0, miscompares = 0, tests_run = 0;
	logic [1:0] tc[6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
	logic [12:0] tr[6] = '{13'h1c, 13'h1d, 13'h0, 13'h1001, 13'h1, 13'h1c};
	logic te[6] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1};
	fpd_top dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.scale_a_pin(sa), .scale_b_pin(sb), .scale_ref_pin(sr), .scale_zero_id_pin(zid), .detected_pitch(dp),
		.motor_speed(spd), .feedback_phase_first_out(fa), .feedback_phase_first_out_n(fan),
		.feedback_phase_second_out(fb), .feedback_phase_second_out_n(fbn), .feedback_index_out(fx),
		.feedback_index_out_n(fxn), .setting_alarm(sal), .overspeed_alarm(oal), .move_dir(dir));
	fpd_host host (.clk, .rst, .ph_a(fa), .ph_b(fb), .idx(fx), .pos, .idx_cnt(icnt));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : check
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		bus(1'h0, a, 32'h0);
		check(nm, q, e);
	endtask : rd
	task automatic restart(input logic [31:0] c);
		wr(12'h000, c | 32'h8);
		repeat (4) @(posedge clk);
	endtask : restart
	// scale moves a gray step, second phase leading when forward, held 5 cycles
	task automatic step(input int d, input int n);
		repeat (n) begin
			ph = ph + d[1:0];
			sa <= ph[1];
			sb <= ph[0] ^ ph[1];
			repeat (5) @(posedge clk);
		end
	endtask : step
	task automatic xi(input int d, input logic [1:0] id, input int e);
		step(d, 1);
		zid <= id;
		sr <= 1'h1;
		step(d, 4);
		sr <= 1'h0;
		step(d, 4);
		check("index count", icnt, e);
	endtask : xi
	task automatic sp(input logic [15:0] s, input logic e);
		spd <= s;
		repeat (8) @(posedge clk);
		check("overspeed", oal, e);
	endtask : sp
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		rd(12'h004, 32'h14, "res");
		rd(12'h008, 32'h7d0, "pitch");
		rd(12'h00c, 32'h32, "maxspd");
		rd(12'h010, 32'h1000, "edges");
		rd(12'h014, 32'h1400, "status");
		rd(12'h020, 32'h0, "unmapped");
		check("slverr", err, 1'h1);
		$display("test reset done");
		wr(12'h004, 32'h10);
		wr(12'h010, 32'h10);
		restart(32'h4);
		rd(12'h000, 32'h4, "ctrl");
		p0 = pos;
		step(1, 8);
		check("fwd", pos - p0, 8);
		rd(12'h014, 32'h1020, "status");
		step(-1, 4);
		check("rev", pos - p0, 4);
		wr(12'h004, 32'h8);
		restart(32'h0);
		p0 = pos;
		step(1, 16);
		check("half", pos - p0, 8);
		$display("test divide done");
		wr(12'h004, 32'h10);
		restart(32'h0);
		xi(-1, 2'h1, 0);
		xi(1, 2'h0, 1);
		xi(-1, 2'h0, 1);
		restart(32'h1);
		xi(-1, 2'h0, 1);
		xi(1, 2'h0, 2);
		xi(-1, 2'h0, 3);
		xi(-1, 2'h1, 3);
		restart(32'h2);
		xi(-1, 2'h2, 4);
		$display("test index done");
		dp <= 32'h30007;
		rd(12'h018, 32'h7, "mon lo");
		rd(12'h01c, 32'h3, "mon hi");
		dp <= 32'h7d0;
		wr(12'h010, 32'h1000);
		wr(12'h008, 32'h64);
		for (int i = 0; i < 6; i++) begin
			wr(12'h004, {19'h0, tr[i]});
			restart({30'h0, tc[i]});
			check("setting alarm", sal, te[i]);
		end
		p0 = pos;
		step(1, 4);
		check("halted", pos - p0, 0);
		$display("test limits done");
		restart(32'h0);
		sp(16'h32, 1'h0);
		sp(16'h3c, 1'h1);
		sp(16'h0, 1'h1);
		restart(32'h0);
		check("overspeed clr", oal, 1'h0);
		wr(12'h008, 32'h190);
		wr(12'h004, 32'h4);
		restart(32'h2);
		sp(16'ha, 1'h0);
		sp(16'hb, 1'h1);
		spd <= 16'h0;
		$display("test overspeed done");
		close_out();
	end
endmodule : scale_feedback_pulse_divider_test
